// File: rtl/ae_consts.svh
`ifndef AE_CONSTS_SVH
`define AE_CONSTS_SVH

// Register offsets (byte addresses)
`define OFS_CTRL     8'h00
`define OFS_THRESH   8'h04
`define OFS_END_TMO  8'h08
`define OFS_SLICE    8'h0C
`define OFS_LIMIT    8'h10
`define OFS_STATINT  8'h14
`define OFS_SESSION  8'h18
`define OFS_STATE    8'h1C
`define OFS_TIME     8'h20

// Field positions
`define CTRL_MODE_BIT   0
`define CTRL_RUN_BIT    1
`define SESS_HELD_BIT   0
`define SESS_REFUSE_BIT 1

// Reset values
`define RST_THRESH   16'h0100
`define RST_END_TMO  32'h0000_0190
`define RST_SLICE    32'h0000_2710
`define RST_LIMIT    16'h0100
`define RST_STATINT  32'h0001_3880

// Timing and scaling
`define CLK_KHZ      20000
`define HOLD_MS      30
`define FULL_SCALE   32767
`define SAT_PCT      95
`define DB_PER_BIT   6
`define DB_OFFSET    8'h00
`define UV_PER_LSB   32'h0000_0001

`endif

// File: rtl/ae_pkg.sv
package ae_pkg;

  typedef enum logic {
    MODE_HIT  = 1'b0,
    MODE_CONT = 1'b1
  } meas_mode_t;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_BURST = 1'b1
  } chan_state_t;

  typedef enum logic {
    REC_FEATURE = 1'b0,
    REC_STATUS  = 1'b1
  } rec_kind_t;

  typedef struct packed {
    rec_kind_t   kind;
    logic        chan;
    logic [31:0] waveform_index;
    logic [31:0] arrival_time;
    logic [31:0] duration;
    logic [31:0] rise_time;
    logic [15:0] peak_amplitude;
    logic [7:0]  peak_amplitude_db;
    logic [31:0] peak_amplitude_linear;
    logic [47:0] energy;
    logic [15:0] ringdown_count;
    logic [23:0] rms;
  } data_rec_t;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] sample;
  } raw_stream_t;

  typedef struct packed {
    logic burst;
    logic saturated;
  } indicator_t;

endpackage

// File: rtl/ae_feature_extractor.sv
// Notes on behaviour
// - Two modes: hit-based or continuous slices
// - Burst starts when signal exceeds threshold
// - Burst ends after quiet burst_end_timeout
// - Continuous mode: equal slices, one record each
// - Slice: peak, energy, peak delay, crossings
// - Slice length, peak delay, start as fields
// - Duration is last minus first crossing
// - Risetime is peak time minus first crossing
// - Peak reported in dB and linear
// - Energy sums squared voltage over duration
// - Count upward crossings of positive threshold
// - Burst record carries RMS of burst
// - Arrival time is first crossing time
// - Each feature record carries a waveform index
// - Periodic status records: interval RMS, energy
// - Only one client session at once
// - Control on the register port, data on a separate record port
// - Raw sample stream per channel, separate
// - Threshold, burst, saturation indications held 30 ms
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "ae_consts.svh"

module ae_feature_extractor
  import ae_pkg::*;
#(
  parameter int HOLD_CYCLES = `HOLD_MS * `CLK_KHZ
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  input  wire logic               ce_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [31:0]        rdata_o,
  input  wire logic signed [15:0] adc0_i,
  input  wire logic signed [15:0] adc1_i,
  output data_rec_t               rec_o,
  output logic                    rec_valid_o,
  output raw_stream_t             raw0_o,
  output raw_stream_t             raw1_o,
  output indicator_t              ind0_o,
  output indicator_t              ind1_o
);

  localparam logic [15:0] SAT_LEVEL = 16'((`FULL_SCALE * `SAT_PCT) / 100);
  localparam logic [19:0] HOLD_LD   = 20'(HOLD_CYCLES);

  function automatic logic [23:0] isqrt(input logic [47:0] v);
    logic [23:0] r;
    logic [23:0] t;
    r = 24'h000000;
    for (int i = 23; i >= 0; i--) begin
      t = r | (24'h000001 << i);
      if (48'(t) * 48'(t) <= v) begin
        r = t;
      end
    end
    return r;
  endfunction

  function automatic logic [23:0] rms_of(input logic [47:0] e, input logic [31:0] n);
    logic [23:0] r;
    r = 24'h000000;
    if (n != 32'h00000000) begin
      r = isqrt(e / 48'(n));
    end
    return r;
  endfunction

  // Roughly 6 dB per bit of magnitude; coarse log scale without a table
  function automatic logic [7:0] db_of(input logic [15:0] m);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        p = 8'(i + 1);
      end
    end
    return 8'(p * `DB_PER_BIT) + `DB_OFFSET;
  endfunction

  // Control registers
  meas_mode_t  mode_ff;
  logic        run_ff;
  logic [15:0] thresh_ff;
  logic [31:0] end_tmo_ff;
  logic [31:0] slice_ff;
  logic [15:0] limit_ff;
  logic [31:0] statint_ff;
  logic        session_ff;
  logic        refused_ff;
  logic [31:0] tstamp_ff;
  logic [31:0] stat_cnt_ff;

  // Per-channel state
  logic signed [15:0] s1_ff       [2];
  logic signed [15:0] s2_ff       [2];
  logic signed [15:0] prev_ff     [2];
  chan_state_t        st_ff       [2];
  logic [31:0]        first_ff    [2];
  logic [31:0]        last_ff     [2];
  logic [31:0]        peakt_ff    [2];
  logic [31:0]        n_ff        [2];
  logic [31:0]        nlast_ff    [2];
  logic [31:0]        quiet_ff    [2];
  logic [31:0]        slice_cnt_ff[2];
  logic [31:0]        widx_ff     [2];
  logic [15:0]        peak_ff     [2];
  logic [15:0]        cnt_ff      [2];
  logic [47:0]        e_ff        [2];
  logic [47:0]        elast_ff    [2];
  logic [47:0]        se_ff       [2];
  logic [19:0]        thr_hold_ff [2];
  logic [19:0]        sat_hold_ff [2];
  indicator_t         ind_ff      [2];
  raw_stream_t        raw_ff      [2];

  // Record sources: 0,1 feature per channel; 2,3 status per channel
  logic               pend_ff     [4];
  data_rec_t          prec_ff     [4];
  logic               gnt_w       [4];
  wire logic signed [15:0] adc_w  [2];

  wire logic ctl_wr_w  = wr_i & session_ff;
  wire logic hit_w     = (mode_ff == MODE_HIT);
  wire logic [31:0] end_tmo_w = (end_tmo_ff == 32'h0) ? 32'h1 : end_tmo_ff;
  wire logic [31:0] slice_w   = (slice_ff == 32'h0) ? 32'h1 : slice_ff;
  wire logic [31:0] stat_w    = (statint_ff == 32'h0) ? 32'h1 : statint_ff;
  // Reaching or passing the count ticks, so a shortened interval cannot stall
  wire logic stat_tick_w = run_ff & (stat_cnt_ff >= stat_w - 32'h1);

  assign adc_w[0] = adc0_i;
  assign adc_w[1] = adc1_i;

  // Register bus
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mode_ff    <= MODE_HIT;
      run_ff     <= 1'b0;
      thresh_ff  <= `RST_THRESH;
      end_tmo_ff <= `RST_END_TMO;
      slice_ff   <= `RST_SLICE;
      limit_ff   <= `RST_LIMIT;
      statint_ff <= `RST_STATINT;
      session_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && addr_i == `OFS_SESSION) begin
        if (wdata_i[`SESS_REFUSE_BIT]) begin
          refused_ff <= 1'b0;
        end
        // A refused claim in the same write beats the clear
        if (!wdata_i[`SESS_HELD_BIT]) begin
          session_ff <= 1'b0;
          run_ff     <= 1'b0;
        end else if (session_ff) begin
          refused_ff <= 1'b1;
        end else begin
          session_ff <= 1'b1;
        end
      end
      if (ctl_wr_w) begin
        unique case (addr_i)
          `OFS_CTRL: begin
            mode_ff <= meas_mode_t'(wdata_i[`CTRL_MODE_BIT]);
            run_ff  <= wdata_i[`CTRL_RUN_BIT];
          end
          `OFS_THRESH:  thresh_ff  <= wdata_i[15:0];
          `OFS_END_TMO: end_tmo_ff <= wdata_i;
          `OFS_SLICE:   slice_ff   <= wdata_i;
          `OFS_LIMIT:   limit_ff   <= wdata_i[15:0];
          `OFS_STATINT: statint_ff <= wdata_i;
          default: ;
        endcase
      end
    end
  end

  wire logic [31:0] state_w = {26'h0, ind_ff[1].saturated, ind_ff[0].saturated,
                               st_ff[1] == ST_BURST, st_ff[0] == ST_BURST, run_ff, mode_ff == MODE_CONT};
  logic [31:0] rd_mux_w;
  always_comb begin
    unique case (addr_i)
      `OFS_CTRL:    rd_mux_w = {30'h0, run_ff, mode_ff == MODE_CONT};
      `OFS_THRESH:  rd_mux_w = {16'h0, thresh_ff};
      `OFS_END_TMO: rd_mux_w = end_tmo_ff;
      `OFS_SLICE:   rd_mux_w = slice_ff;
      `OFS_LIMIT:   rd_mux_w = {16'h0, limit_ff};
      `OFS_STATINT: rd_mux_w = statint_ff;
      `OFS_SESSION: rd_mux_w = {30'h0, refused_ff, session_ff};
      `OFS_STATE:   rd_mux_w = state_w;
      `OFS_TIME:    rd_mux_w = tstamp_ff;
      default:      rd_mux_w = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h0;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux_w : 32'h0;
    end
  end

  // Time base and status interval timer
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tstamp_ff   <= 32'h0;
      stat_cnt_ff <= 32'h0;
    end else if (ce_i) begin
      tstamp_ff   <= tstamp_ff + 32'h1;
      stat_cnt_ff <= (!run_ff || stat_tick_w) ? 32'h0 : stat_cnt_ff + 32'h1;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_chan
    wire logic signed [15:0] x_w   = s2_ff[g];
    wire logic [15:0]        mag_w = x_w[15] ? 16'(-x_w) : 16'(x_w);
    wire logic [47:0]        sq_w  = 48'(mag_w) * 48'(mag_w);
    wire logic               above_w = mag_w > thresh_ff;
    wire logic signed [15:0] lvl_w = hit_w ? $signed(thresh_ff) : $signed(limit_ff);
    wire logic cross_w  = (x_w > lvl_w) && (prev_ff[g] <= lvl_w);
    wire logic idle_w   = (st_ff[g] == ST_IDLE);
    wire logic start_w  = run_ff & (hit_w ? (idle_w & above_w) : (slice_cnt_ff[g] == 32'h0));
    wire logic [31:0] nxt_first  = start_w ? tstamp_ff : first_ff[g];
    wire logic [47:0] nxt_e      = start_w ? sq_w : e_ff[g] + sq_w;
    wire logic [31:0] nxt_n      = start_w ? 32'h1 : n_ff[g] + 32'h1;
    wire logic        new_pk_w   = start_w | (mag_w > peak_ff[g]);
    wire logic [15:0] nxt_peak   = new_pk_w ? mag_w : peak_ff[g];
    wire logic [31:0] nxt_peakt  = new_pk_w ? tstamp_ff : peakt_ff[g];
    wire logic [15:0] nxt_cnt    = start_w ? 16'(cross_w) : cnt_ff[g] + 16'(cross_w);
    wire logic [31:0] nxt_last   = (start_w | above_w) ? tstamp_ff : last_ff[g];
    wire logic        keep_w     = above_w | start_w | !hit_w;
    // Energy and RMS stop at the last crossing, not at the timeout
    wire logic [47:0] nxt_elast  = keep_w ? nxt_e : elast_ff[g];
    wire logic [31:0] nxt_nlast  = keep_w ? nxt_n : nlast_ff[g];
    wire logic [31:0] nxt_quiet  = (start_w | above_w) ? 32'h0 : quiet_ff[g] + 32'h1;
    wire logic fin_w = run_ff & (hit_w ? (!idle_w & !above_w & (nxt_quiet >= end_tmo_w))
                                       : (slice_cnt_ff[g] == slice_w - 32'h1));
    wire logic [31:0] dur_w = hit_w ? nxt_last - nxt_first : slice_w;
    wire logic [47:0] nxt_se = stat_tick_w ? 48'h0 : se_ff[g] + sq_w;
    wire logic [47:0] stat_e_w = se_ff[g] + sq_w;

    wire data_rec_t frec_w = '{
      kind:                  REC_FEATURE,
      chan:                  1'(g),
      waveform_index:        widx_ff[g],
      arrival_time:          nxt_first,
      duration:              dur_w,
      rise_time:             nxt_peakt - nxt_first,
      peak_amplitude:        nxt_peak,
      peak_amplitude_db:     db_of(nxt_peak),
      peak_amplitude_linear: 32'(32'(nxt_peak) * `UV_PER_LSB),
      energy:                nxt_elast,
      ringdown_count:        nxt_cnt,
      rms:                   rms_of(nxt_elast, nxt_nlast)
    };
    wire data_rec_t srec_w = '{
      kind:                  REC_STATUS,
      chan:                  1'(g),
      waveform_index:        32'h0,
      arrival_time:          tstamp_ff,
      duration:              stat_w,
      rise_time:             32'h0,
      peak_amplitude:        16'h0,
      peak_amplitude_db:     8'h00,
      peak_amplitude_linear: 32'h0,
      energy:                stat_e_w,
      ringdown_count:        16'h0,
      rms:                   rms_of(stat_e_w, stat_w)
    };

    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        s1_ff[g]   <= 16'sh0000;
        s2_ff[g]   <= 16'sh0000;
        prev_ff[g] <= 16'sh0000;
        raw_ff[g]  <= '0;
      end else if (ce_i) begin
        s1_ff[g]   <= adc_w[g];
        s2_ff[g]   <= s1_ff[g];
        prev_ff[g] <= x_w;
        raw_ff[g]  <= '{valid: run_ff, sample: x_w};
      end
    end

    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        st_ff[g]        <= ST_IDLE;
        first_ff[g]     <= 32'h0;
        last_ff[g]      <= 32'h0;
        peakt_ff[g]     <= 32'h0;
        n_ff[g]         <= 32'h0;
        nlast_ff[g]     <= 32'h0;
        quiet_ff[g]     <= 32'h0;
        slice_cnt_ff[g] <= 32'h0;
        widx_ff[g]      <= 32'h0;
        peak_ff[g]      <= 16'h0;
        cnt_ff[g]       <= 16'h0;
        e_ff[g]         <= 48'h0;
        elast_ff[g]     <= 48'h0;
      end else if (ce_i) begin
        if (!run_ff) begin
          st_ff[g]        <= ST_IDLE;
          slice_cnt_ff[g] <= 32'h0;
        end else begin
          if (start_w || !idle_w) begin
            first_ff[g] <= nxt_first;
            last_ff[g]  <= nxt_last;
            peakt_ff[g] <= nxt_peakt;
            n_ff[g]     <= nxt_n;
            nlast_ff[g] <= nxt_nlast;
            quiet_ff[g] <= nxt_quiet;
            peak_ff[g]  <= nxt_peak;
            cnt_ff[g]   <= nxt_cnt;
            e_ff[g]     <= nxt_e;
            elast_ff[g] <= nxt_elast;
          end
          if (start_w) begin
            widx_ff[g] <= {31'(widx_ff[g][31:1] + 31'h1), 1'(g)};
          end
          unique case (st_ff[g])
            ST_IDLE:  st_ff[g] <= (start_w && !fin_w) ? ST_BURST : ST_IDLE;
            ST_BURST: st_ff[g] <= fin_w ? ST_IDLE : ST_BURST;
          endcase
          slice_cnt_ff[g] <= (hit_w || fin_w) ? 32'h0 : slice_cnt_ff[g] + 32'h1;
        end
      end
    end

    // Set beats grant; a record not yet sent when the next one lands is overwritten
    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        pend_ff[g]     <= 1'b0;
        pend_ff[g + 2] <= 1'b0;
        prec_ff[g]     <= '0;
        prec_ff[g + 2] <= '0;
        se_ff[g]       <= 48'h0;
      end else if (ce_i) begin
        se_ff[g] <= run_ff ? nxt_se : 48'h0;
        if (fin_w) begin
          pend_ff[g] <= 1'b1;
          prec_ff[g] <= frec_w;
        end else if (gnt_w[g]) begin
          pend_ff[g] <= 1'b0;
        end
        if (stat_tick_w) begin
          pend_ff[g + 2] <= 1'b1;
          prec_ff[g + 2] <= srec_w;
        end else if (gnt_w[g + 2]) begin
          pend_ff[g + 2] <= 1'b0;
        end
      end
    end

    // Indicator hold counters
    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        thr_hold_ff[g] <= 20'h0;
        sat_hold_ff[g] <= 20'h0;
        ind_ff[g]      <= '0;
      end else if (ce_i) begin
        thr_hold_ff[g] <= start_w ? HOLD_LD
                        : (thr_hold_ff[g] != 20'h0) ? thr_hold_ff[g] - 20'h1 : 20'h0;
        sat_hold_ff[g] <= (mag_w > SAT_LEVEL) ? HOLD_LD
                        : (sat_hold_ff[g] != 20'h0) ? sat_hold_ff[g] - 20'h1 : 20'h0;
        ind_ff[g].burst     <= start_w | (thr_hold_ff[g] > 20'h1);
        ind_ff[g].saturated <= (mag_w > SAT_LEVEL) | (sat_hold_ff[g] > 20'h1);
      end
    end
  end

  // Single data port: fixed priority, one record per cycle
  assign gnt_w[0] = pend_ff[0];
  assign gnt_w[1] = pend_ff[1] & !pend_ff[0];
  assign gnt_w[2] = pend_ff[2] & !pend_ff[0] & !pend_ff[1];
  assign gnt_w[3] = pend_ff[3] & !pend_ff[0] & !pend_ff[1] & !pend_ff[2];

  wire data_rec_t sel_rec_w = gnt_w[0] ? prec_ff[0] : gnt_w[1] ? prec_ff[1]
                            : gnt_w[2] ? prec_ff[2] : prec_ff[3];
  wire logic any_w = pend_ff[0] | pend_ff[1] | pend_ff[2] | pend_ff[3];

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rec_o       <= '0;
      rec_valid_o <= 1'b0;
    end else if (ce_i) begin
      rec_valid_o <= any_w;
      if (any_w) begin
        rec_o <= sel_rec_w;
      end
    end
  end

  assign raw0_o = raw_ff[0];
  assign raw1_o = raw_ff[1];
  assign ind0_o = ind_ff[0];
  assign ind1_o = ind_ff[1];

endmodule // ae_feature_extractor

// File: dv/ae_feature_extractor_sva.sv
`timescale 1ns/1ps
`include "ae_consts.svh"
module ae_feature_extractor_sva
  import ae_pkg::*;
#(
  parameter int HOLD_CYCLES = `HOLD_MS * `CLK_KHZ
) (
  input wire logic               mclk_i,
  input wire logic               rst_b_i,
  input wire logic               ce_i,
  input wire logic [7:0]         addr_i,
  input wire logic [31:0]        wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [31:0]        rdata_o,
  input wire logic signed [15:0] adc0_i,
  input wire logic signed [15:0] adc1_i,
  input wire data_rec_t          rec_o,
  input wire logic               rec_valid_o,
  input wire raw_stream_t        raw0_o,
  input wire raw_stream_t        raw1_o,
  input wire indicator_t         ind0_o,
  input wire indicator_t         ind1_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  int hold_cnt_ff;
  wire feat = rec_valid_o && rec_o.kind == REC_FEATURE;
  function automatic logic over(logic signed [15:0] s);
    return s > 16'sh7997 || s < -16'sh7997;
  endfunction
  // Length of the current high run of the burst flag
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || !ind0_o.burst)
      hold_cnt_ff <= 0;
    else
      hold_cnt_ff <= hold_cnt_ff + 1;
  end
  a_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (ce_i && rd_i && addr_i >= 8'h24 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_session_width: assert property (ce_i && rd_i && addr_i == `OFS_SESSION |=> rdata_o[31:2] == 30'h0)
    else $error("session word upper bits set");
  a_rec_hold: assert property ($changed(rec_o) |-> rec_valid_o)
    else $error("record changed without valid");
  a_raw0_delay: assert property ($past(ce_i) && $past(ce_i, 2) && $past(ce_i, 3) && raw0_o.valid
    |-> raw0_o.sample == $past(adc0_i, 3)) else $error("raw stream 0 sample mismatch");
  a_raw1_delay: assert property ($past(ce_i) && $past(ce_i, 2) && $past(ce_i, 3) && raw1_o.valid
    |-> raw1_o.sample == $past(adc1_i, 3)) else $error("raw stream 1 sample mismatch");
  a_burst_hold: assert property ($fell(ind0_o.burst) |-> hold_cnt_ff >= HOLD_CYCLES - 2)
    else $error("burst flag dropped early");
  a_sat_hold: assert property ($rose(ind1_o.saturated) |-> ind1_o.saturated[*8])
    else $error("saturation flag dropped early");
  a_sat_cause: assert property ($rose(ind1_o.saturated)
    |-> over($past(adc1_i, 2)) || over($past(adc1_i, 3)) || over($past(adc1_i, 4)))
    else $error("saturation flag without cause");
  a_rise_bound: assert property (feat |-> rec_o.rise_time <= rec_o.duration)
    else $error("rise time beyond duration");
  a_rms_bound: assert property (feat |-> rec_o.rms <= 24'(rec_o.peak_amplitude))
    else $error("rms above peak");
  a_linear_peak: assert property (feat |-> rec_o.peak_amplitude_linear == 32'(rec_o.peak_amplitude))
    else $error("linear peak mismatch");
  a_index_chan: assert property (feat |-> rec_o.waveform_index[0] == rec_o.chan)
    else $error("index channel bit mismatch");
  c_hit: cover property (feat && rec_o.ringdown_count == 16'h3);
  c_status: cover property (rec_valid_o && rec_o.kind == REC_STATUS);
  c_sat: cover property ($rose(ind1_o.saturated));
endmodule // ae_feature_extractor_sva

bind ae_feature_extractor ae_feature_extractor_sva #(.HOLD_CYCLES(HOLD_CYCLES)) ae_feature_extractor_sva_i (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .adc0_i(adc0_i), .adc1_i(adc1_i), .rec_o(rec_o),
  .rec_valid_o(rec_valid_o), .raw0_o(raw0_o), .raw1_o(raw1_o), .ind0_o(ind0_o), .ind1_o(ind1_o));

// File: dv/ae_client_model.sv
`timescale 1ns/1ps
module ae_client_model
  import ae_pkg::*;
(
  input wire logic        mclk_i,
  input wire data_rec_t   rec_i,
  input wire logic        rec_valid_i,
  input wire raw_stream_t raw0_i,
  input wire raw_stream_t raw1_i
);
  data_rec_t   recs[$];
  int unsigned raw_cnt[2] = '{0, 0};
  // Takes every record and every raw sample; never stalls the device
  always @(posedge mclk_i) begin
    if (rec_valid_i)
      recs.push_back(rec_i);
    if (raw0_i.valid)
      raw_cnt[0]++;
    if (raw1_i.valid)
      raw_cnt[1]++;
  end
endmodule // ae_client_model

// File: dv/ae_feature_extractor_test.sv
`timescale 1ns/1ps
`include "ae_consts.svh"
module ae_feature_extractor_test
  import ae_pkg::*;
;
  logic               clk, rst_b, ce, wr, rd, rec_v;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata;
  logic signed [15:0] adc0, adc1;
  logic signed [15:0] s[5];
  logic [47:0]        e;
  data_rec_t          rec, r, p;
  raw_stream_t        raw0, raw1;
  indicator_t         ind0, ind1;
  int                 errors = 0, total_checks = 0, cyc = 0, seed, pat, pk, k;
  logic [7:0]         ofs[5] = '{`OFS_THRESH, 8'h08, `OFS_SLICE, `OFS_LIMIT, `OFS_STATINT};
  logic [31:0]        rv[5] = '{`RST_THRESH, 32'h190, `RST_SLICE, `RST_LIMIT, `RST_STATINT};

  ae_feature_extractor #(.HOLD_CYCLES(20)) ae_feature_extractor_i (
    .mclk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .adc0_i(adc0), .adc1_i(adc1), .rec_o(rec),
    .rec_valid_o(rec_v), .raw0_o(raw0), .raw1_o(raw1), .ind0_o(ind0), .ind1_o(ind1));
  ae_client_model ae_client_model_i (.mclk_i(clk), .rec_i(rec), .rec_valid_i(rec_v), .raw0_i(raw0), .raw1_i(raw1));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end
  // Background patterns for slice and status runs
  always @(posedge clk) begin
    if (pat == 1) begin
      adc0 <= (adc0 == 16'sh0200) ? 16'sh0000 : 16'sh0200;
      adc1 <= 16'sh0080;
    end else if (pat == 2) begin
      adc0 <= 16'sh0040;
      adc1 <= 16'sh0040;
    end
  end

  task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic wr32(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdchk(string n, logic [7:0] a, logic [31:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdata, x);
  endtask
  task automatic take(output data_rec_t x);
    int n;
    n = 0;
    while (ae_client_model_i.recs.size() == 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("record present", ae_client_model_i.recs.size() != 0, 1'b1);
    x = ae_client_model_i.recs.pop_front();
  endtask
  function automatic logic [23:0] isqrt(logic [47:0] x);
    logic [23:0] q;
    q = 24'h0;
    for (int b = 23; b >= 0; b--)
      if ((q | (24'h1 << b)) * (q | (24'h1 << b)) <= x)
        q = q | (24'h1 << b);
    return q;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    seed = 32'hED8ACC18;
    {rst_b, wr, rd, addr, wdata, adc0, adc1, pat} = '0;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wr32(`OFS_THRESH, 32'h55);
    foreach (ofs[i]) rdchk("reset value", ofs[i], rv[i]);
    wr32(`OFS_SESSION, 32'h1);
    wr32(`OFS_SESSION, 32'h3);
    rdchk("second claim", `OFS_SESSION, 32'h3);
    wr32(`OFS_SESSION, 32'h2);
    rdchk("released", `OFS_SESSION, 32'h0);
    wr32(`OFS_SESSION, 32'h1);
    wr32(8'h40, 32'h5);
    rdchk("unmapped", 8'h40, 32'h0);
    wr32(8'h08, 32'h4);
    wr32(`OFS_STATINT, 32'hFFFF_FFFF);
    wr32(`OFS_CTRL, 32'h2);
    rdchk("state", `OFS_STATE, 32'h2);
    // Random bursts with short dips that must not end the burst
    for (int n = 0; n < 4; n++) begin
      pk = 2 * int'(($random(seed) & 32'h7) % 3);
      e = 48'h0;
      for (int i = 0; i < 5; i++) begin
        s[i] = (i % 2) ? 16'($random(seed) & 32'hFF) : 16'h0101 + 16'($random(seed) & 32'h1FFF);
        if (i == pk)
          s[i] = 16'sh6000;
        e = e + 48'(s[i]) * 48'(s[i]);
        @(posedge clk);
        adc0 <= s[i];
      end
      @(posedge clk);
      adc0 <= 16'sh0000;
      repeat (15) @(posedge clk);
      take(r);
      chk("extra record", ae_client_model_i.recs.size(), 0);
      chk("kind", r.kind, REC_FEATURE);
      chk("duration", r.duration, 32'h4);
      chk("rise", r.rise_time, 32'(pk));
      chk("peak", r.peak_amplitude, 16'h6000);
      chk("peak db", r.peak_amplitude_db, 8'(15 * `DB_PER_BIT) + `DB_OFFSET);
      chk("energy", r.energy, e);
      chk("counts", r.ringdown_count, 16'h3);
      chk("rms", r.rms, isqrt(e / 5));
      if (n > 0) begin
        chk("arrival gap", r.arrival_time - p.arrival_time, 32'h15);
        chk("index step", r.waveform_index - p.waveform_index, 32'h2);
      end
      p = r;
    end
    wr32(`OFS_SLICE, 32'h8);
    pat = 1;
    wr32(`OFS_CTRL, 32'h3);
    repeat (30) @(posedge clk);
    #1 ae_client_model_i.recs.delete();
    repeat (40) @(posedge clk);
    #1 chk("raw separate", raw1.sample, 16'h0080);
    k = 0;
    while (ae_client_model_i.recs.size() != 0) begin
      r = ae_client_model_i.recs.pop_front();
      chk("slice length", r.duration, 32'h8);
      chk("slice peak", r.peak_amplitude, r.chan ? 16'h80 : 16'h200);
      chk("slice energy", r.energy, r.chan ? 48'h20000 : 48'h100000);
      chk("slice crossings", r.ringdown_count, r.chan ? 16'h0 : 16'h4);
      chk("slice rms", r.rms, r.chan ? 24'h80 : 24'h16A);
      if (r.chan) begin
        if (k > 0)
          chk("slice start", r.arrival_time - p.arrival_time, 32'h8);
        p = r;
        k++;
      end
    end
    chk("slice records", k > 3, 1'b1);
    pat = 2;
    wr32(`OFS_CTRL, 32'h2);
    wr32(`OFS_STATINT, 32'h10);
    repeat (60) @(posedge clk);
    #1 ae_client_model_i.recs.delete();
    repeat (40) @(posedge clk);
    #1 chk("status records", ae_client_model_i.recs.size() >= 4, 1'b1);
    while (ae_client_model_i.recs.size() != 0) begin
      r = ae_client_model_i.recs.pop_front();
      chk("status kind", r.kind, REC_STATUS);
      chk("status energy", r.energy, 48'h10000);
      chk("status rms", r.rms, 24'h40);
    end
    pat = 0;
    @(posedge clk);
    adc1 <= 16'sh7FFF;
    @(posedge clk);
    adc1 <= 16'sh0000;
    repeat (5) @(posedge clk);
    #1 chk("saturated", ind1.saturated, 1'b1);
    chk("burst flag", ind1.burst, 1'b1);
    repeat (30) @(posedge clk);
    #1 chk("flags expire", {ind1.saturated, ind1.burst}, 2'b00);
    wr32(`OFS_SESSION, 32'h0);
    repeat (5) @(posedge clk);
    #1 chk("raw stops", raw0.valid, 1'b0);
    chk("raw taken", ae_client_model_i.raw_cnt[0] > 0, 1'b1);
    print_verdict();
  end
endmodule // ae_feature_extractor_test
